/* pdhp_cfg.svh */
`ifndef PDHP_CFG_SVH
`define PDHP_CFG_SVH
// Target select codes (hi,lo)
`define PDHP_SEL_ADDR      2'h0
`define PDHP_SEL_PAL       2'h1
`define PDHP_SEL_CTRL      2'h2
`define PDHP_SEL_MODE      2'h3
// Control register indices
`define PDHP_IDX_PIXCAP    8'h00
`define PDHP_IDX_DACCAP    8'h01
`define PDHP_IDX_SBTEST    8'h02
`define PDHP_IDX_IDENT     8'h03
`define PDHP_IDX_MASK      8'h04
`define PDHP_IDX_CMD1      8'h05
`define PDHP_IDX_CMD2      8'h06
`define PDHP_IDX_CMD3      8'h07
`define PDHP_IDX_REV       8'h0B
// Reset values
`define PDHP_MODE_RST      8'hFF
`define PDHP_CMD1_RST      8'h00
`define PDHP_CMD2_RST      8'hFF
`define PDHP_CMD3_RST      8'hFF
`define PDHP_MASK_RST      8'hFF
// Mode register fields
`define PDHP_MB_RESTART    0
`define PDHP_MB_RES        1
`define PDHP_MB_WIDTH      2
`define PDHP_MB_OPLO       3
`define PDHP_MB_OPHI       4
`define PDHP_MB_CAL        5
`define PDHP_MB_MATCHLO    6
`define PDHP_MB_MATCHHI    7
// Power-on reset time and clock dividers
`define PDHP_POR_NS        1000
`define PDHP_CLK_NS        8
`define PDHP_POR_CYC       ((`PDHP_POR_NS + `PDHP_CLK_NS - 1) / `PDHP_CLK_NS)
`define PDHP_PRG_HALF      5'h0F
`define PDHP_LOAD_HALF     5'h01
`define PDHP_LAST_ENTRY    8'hFF
`endif

/* pdhp_pkg.sv */
`default_nettype none
package pdhp_pkg;
  // Colour pointer, one-hot
  typedef enum logic [2:0] {
    PDHP_RED   = 3'h1,
    PDHP_GREEN = 3'h2,
    PDHP_BLUE  = 3'h4
  } pdhp_colour_t;
  // One host bus cycle as latched
  typedef struct packed {
    logic       rd;
    logic [1:0] sel;
    logic [9:0] data;
  } pdhp_req_t;
  // One palette entry
  typedef struct packed {
    logic [9:0] red;
    logic [9:0] green;
    logic [9:0] blue;
  } pdhp_rgb_t;
endpackage : pdhp_pkg
`default_nettype wire

/* pdhp_host_port.sv */
`include "pdhp_cfg.svh"
`default_nettype none

// How it works
// - Select 11 reads/writes mode register low byte.
// - Select 00 reads/writes address register.
// - Select 10 reaches control register at address.
// - 8-bit mode: palette values take two cycles.
// - First cycle carries colour bits 9..2.
// - Second cycle carries colour bits 1..0.
// - Blue write stores entry, then address increments.
// - Palette reads give red, green, blue.
// - Address increments after blue read.
// - Reset sets sequence, mode, command registers.
// - During reset clocks divide by 32, 4.
// - Reset lasts one microsecond; host waits.
// - Host writes start entry; address auto-advances.
// - Mode top two bits read zero.
// - One-zero-one on restart bit resets sequence.
// - Resolution bit chooses 30 or 24 bits.
// - Bus-width bit; lines 9,8 zero in 8-bit.
// - Operating field 01 means normal mode.
// - Calibrate bit rising edge starts calibration.
// - Selected only when select inputs match bits.
// - Index zero reads the low byte of the 24-bit pixel capture.
// - Colour pointer steps; resets on address write.
// - Address wraps to zero after entry 255.
// - Port starts in 10-bit bus mode.
module pdhp_host_port
  import pdhp_pkg::*;
#(
  parameter int        POR_CYCLES = `PDHP_POR_CYC,  // Power-on reset length in cycles
  parameter logic [7:0] ID_CODE   = 8'h5A,           // Arbitrary identity value
  parameter logic [7:0] REV_CODE  = 8'h01            // Arbitrary revision value
) (
  input  wire logic        clk_sys,               // Pixel-rate system clock
  input  wire logic        reset,                 // Synchronous power-on reset
  input  wire logic        chip_enable_n,         // Host strobe, low active, from pin
  input  wire logic        read_not_write,        // 1 read, 0 write
  input  wire logic        target_select_hi,      // Target select upper
  input  wire logic        target_select_lo,      // Target select lower
  input  wire logic [9:0]  host_data_in,          // Bus input lines
  output logic      [9:0]  host_data_out,         // Bus output lines
  output logic      [9:0]  host_data_oe,          // Bus drive enables
  input  wire logic        palette_select_in_hi,  // Palette select pin upper
  input  wire logic        palette_select_in_lo,  // Palette select pin lower
  input  wire logic [23:0] pixel_port_in,         // Pixel port sample for capture
  input  wire logic        pixel_capture_strobe,  // Capture enable (diagnostic)
  input  wire logic [7:0]  palette_rd_index,      // Pixel-side lookup index
  output logic      [29:0] palette_rd_data,       // Pixel-side lookup, gated
  output logic             device_selected,       // Select match
  output logic             normal_mode,           // Operating field is normal
  output logic             dac_ten_bit,           // Converter resolution
  output logic             sequence_restart,      // Pulse: sampling to first phase
  output logic             calibrate_start,       // Pulse: start calibration
  output logic             programmable_clock_out,// Divided clock output
  output logic             load_clock_out,        // Load clock output
  output logic             por_active,            // Power-on reset in progress
  output logic      [7:0]  command_one,           // Command register one
  output logic      [7:0]  command_two,           // Command register two
  output logic      [7:0]  command_three,         // Command register three
  output logic      [7:0]  pixel_mask             // Pixel mask register
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and strobe edge
  logic       sync1_ff, sync2_ff;    // Strobe pin stages, high while strobe is low
  logic       ce_seen_ff;            // Synced strobe level from the previous cycle
  logic [1:0] psel_ff;               // Select pins after sync

  // Two flops per pin; only the second stage feeds logic
  always_ff @(posedge clk_sys) begin
    sync1_ff <= ~chip_enable_n;
    sync2_ff <= sync1_ff;
  end

  // Select-match pair synchronised separately
  logic [1:0] ps1_ff;
  always_ff @(posedge clk_sys) begin
    ps1_ff  <= {palette_select_in_hi, palette_select_in_lo};
    psel_ff <= ps1_ff;
  end

  // Previous strobe level for rising-edge detect
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ce_seen_ff <= 1'b0;
    end else begin
      ce_seen_ff <= sync2_ff;
    end
  end

  // Control and data pins also pass two stages
  pdhp_req_t req1_ff, req_ff;
  always_ff @(posedge clk_sys) begin
    req1_ff <= '{rd: read_not_write, sel: {target_select_hi, target_select_lo},
                 data: host_data_in};
    req_ff  <= req1_ff;
  end

  logic strobe;  // One cycle per host access
  // Host must hold controls through strobe; sampled on strobe rise
  assign strobe = sync2_ff & ~ce_seen_ff & ~por_active;

  ////////////////////////////////////////////////////////////////////////
  // Power-on reset timer and output dividers
  logic [$clog2(POR_CYCLES+1)-1:0] por_cnt_ff;
  logic [4:0] div_ff;

  // Reset holds the port off for the power-on interval
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      por_cnt_ff <= '0;
    end else if (por_active) begin
      por_cnt_ff <= por_cnt_ff + 1'b1;
    end
  end
  assign por_active = (por_cnt_ff != ($clog2(POR_CYCLES+1))'(POR_CYCLES));

  // Free-running divider; during reset outputs are /32 and /4
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_ff <= 5'h00;
    end else begin
      div_ff <= div_ff + 5'h01;
    end
  end
  // Outside reset the rate fields are not modelled; same dividers kept
  assign programmable_clock_out = div_ff[4];
  assign load_clock_out         = div_ff[1];

  ////////////////////////////////////////////////////////////////////////
  // Mode, address and control registers
  logic [7:0]   mode_ff;       // device_mode low byte
  logic [7:0]   addr_ff;       // index_pointer
  logic [7:0]   cmd1_ff, cmd2_ff, cmd3_ff, mask_ff;
  logic [2:0]   sbtest_ff;     // Sync/blank test bits
  logic [23:0]  pixcap_ff;     // pixel_capture
  pdhp_colour_t colour_ff;     // Colour pointer
  logic         half_ff;       // 0: first of two 8-bit cycles
  logic [29:0]  stage_ff;      // Assembling red/green/blue on writes
  logic [1:0]   restart_seq_ff;
  logic         wr, rd, eight_bit;
  logic [7:0]   nxt_addr;

  assign wr        = strobe & ~req_ff.rd;
  assign rd        = strobe &  req_ff.rd;
  assign eight_bit = ~mode_ff[`PDHP_MB_WIDTH];

  // Palette storage
  pdhp_rgb_t pal_mem [256];

  // Mode register; reset all ones makes the bus 10 bits wide
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_ff <= `PDHP_MODE_RST;
    end else if (wr && req_ff.sel == `PDHP_SEL_MODE) begin
      mode_ff <= req_ff.data[7:0];
    end
  end

  // Restart bit 1-0-1 tracker
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      restart_seq_ff <= 2'h0;
    end else if (wr && req_ff.sel == `PDHP_SEL_MODE) begin
      case ({restart_seq_ff, req_ff.data[`PDHP_MB_RESTART]})
        3'b001:  restart_seq_ff <= 2'h1;
        3'b010:  restart_seq_ff <= 2'h2;
        3'b011:  restart_seq_ff <= 2'h1;
        3'b101:  restart_seq_ff <= 2'h0;
        default: restart_seq_ff <= 2'h0;
      endcase
    end
  end
  assign sequence_restart = reset | (wr && req_ff.sel == `PDHP_SEL_MODE
    && restart_seq_ff == 2'h2 && req_ff.data[`PDHP_MB_RESTART]);

  // Calibration on zero-to-one of the calibrate bit
  assign calibrate_start = wr && req_ff.sel == `PDHP_SEL_MODE
    && !mode_ff[`PDHP_MB_CAL] && req_ff.data[`PDHP_MB_CAL];

  assign dac_ten_bit     = mode_ff[`PDHP_MB_RES];
  assign normal_mode     = !mode_ff[`PDHP_MB_OPHI] && mode_ff[`PDHP_MB_OPLO];
  assign device_selected = psel_ff == {mode_ff[`PDHP_MB_MATCHHI],
                                       mode_ff[`PDHP_MB_MATCHLO]};

  // Entry completes after blue in its last half
  logic pal_acc, last_half, entry_done;
  assign pal_acc    = strobe && req_ff.sel == `PDHP_SEL_PAL;
  assign last_half  = !eight_bit || half_ff;
  assign entry_done = pal_acc && last_half && colour_ff == PDHP_BLUE;

  // Address: written directly, advances after blue, wraps at 255
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      addr_ff <= 8'h00;
    end else if (wr && req_ff.sel == `PDHP_SEL_ADDR) begin
      addr_ff <= req_ff.data[7:0];
    end else if (entry_done) begin
      addr_ff <= nxt_addr;
    end
  end
  assign nxt_addr = (addr_ff == `PDHP_LAST_ENTRY) ? 8'h00 : addr_ff + 8'h01;

  // Colour pointer and half-cycle phase
  always_ff @(posedge clk_sys) begin
    if (reset || (wr && req_ff.sel == `PDHP_SEL_ADDR)) begin
      colour_ff <= PDHP_RED;
      half_ff   <= 1'b0;
    end else if (pal_acc) begin
      half_ff <= eight_bit && !half_ff;
      if (last_half) begin
        case (colour_ff)
          PDHP_RED:   colour_ff <= PDHP_GREEN;
          PDHP_GREEN: colour_ff <= PDHP_BLUE;
          PDHP_BLUE:  colour_ff <= PDHP_RED;
          default:    colour_ff <= PDHP_RED;
        endcase
      end
    end
  end

  // Merges a bus cycle into a 10-bit colour value
  function automatic logic [9:0] merge(input logic [9:0] old, input logic [9:0] bus,
                                       input logic eb, input logic hf);
    if (!eb)     merge = bus;
    else if (!hf) merge = {bus[7:0], old[1:0]};
    else          merge = {old[9:2], bus[1:0]};
  endfunction : merge

  // Stage red/green/blue writes; blue completes the entry
  logic [9:0] cur_val;
  always_comb begin
    case (colour_ff)
      PDHP_RED:   cur_val = stage_ff[29:20];
      PDHP_GREEN: cur_val = stage_ff[19:10];
      default:    cur_val = stage_ff[9:0];
    endcase
  end
  logic [9:0] new_val;
  assign new_val = merge(cur_val, req_ff.data, eight_bit, half_ff);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage_ff <= '0;
    end else if (wr && req_ff.sel == `PDHP_SEL_PAL) begin
      case (colour_ff)
        PDHP_RED:   stage_ff[29:20] <= new_val;
        PDHP_GREEN: stage_ff[19:10] <= new_val;
        default:    stage_ff[9:0]   <= new_val;
      endcase
    end
  end

  // RAM write on the completing blue cycle
  always_ff @(posedge clk_sys) begin
    if (entry_done && !req_ff.rd) begin
      pal_mem[addr_ff] <= {stage_ff[29:10], new_val};
    end
  end

  // Pixel-side lookup; 8-bit resolution zeroes two LSBs
  pdhp_rgb_t pix_ff;
  always_ff @(posedge clk_sys) begin
    pix_ff <= pal_mem[palette_rd_index];
  end
  // Unselected device outputs zero
  assign palette_rd_data = !device_selected ? 30'h0 : dac_ten_bit ? pix_ff :
    {pix_ff.red[9:2], 2'h0, pix_ff.green[9:2], 2'h0, pix_ff.blue[9:2], 2'h0};

  // Control registers, reached through the address register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmd1_ff   <= `PDHP_CMD1_RST;
      cmd2_ff   <= `PDHP_CMD2_RST;
      cmd3_ff   <= `PDHP_CMD3_RST;
      mask_ff   <= `PDHP_MASK_RST;
      sbtest_ff <= 3'h0;
    end else if (wr && req_ff.sel == `PDHP_SEL_CTRL) begin
      case (addr_ff)
        `PDHP_IDX_SBTEST: sbtest_ff <= req_ff.data[2:0];
        `PDHP_IDX_MASK:   mask_ff   <= req_ff.data[7:0];
        `PDHP_IDX_CMD1:   cmd1_ff   <= req_ff.data[7:0];
        `PDHP_IDX_CMD2:   cmd2_ff   <= req_ff.data[7:0];
        `PDHP_IDX_CMD3:   cmd3_ff   <= req_ff.data[7:0];
        default:          ;
      endcase
    end
  end
  assign command_one   = cmd1_ff;
  assign command_two   = cmd2_ff;
  assign command_three = cmd3_ff;
  assign pixel_mask    = mask_ff;

  // Pixel capture, read-only for the host
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pixcap_ff <= 24'h0;
    end else if (pixel_capture_strobe) begin
      pixcap_ff <= pixel_port_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data; driven while the strobe stays low on a read
  logic [9:0] rdata_ff;
  logic [9:0] ram_val;
  pdhp_rgb_t  ram_ent;
  assign ram_ent = pal_mem[addr_ff];
  always_comb begin
    case (colour_ff)
      PDHP_RED:   ram_val = ram_ent.red;
      PDHP_GREEN: ram_val = ram_ent.green;
      default:    ram_val = ram_ent.blue;
    endcase
  end

  // Control read mux; 24-bit capture gives its low byte
  logic [7:0] ctrl_rd;
  always_comb begin
    case (addr_ff)
      `PDHP_IDX_PIXCAP: ctrl_rd = pixcap_ff[7:0];
      `PDHP_IDX_SBTEST: ctrl_rd = {5'h00, sbtest_ff};
      `PDHP_IDX_IDENT:  ctrl_rd = ID_CODE;
      `PDHP_IDX_MASK:   ctrl_rd = mask_ff;
      `PDHP_IDX_CMD1:   ctrl_rd = cmd1_ff;
      `PDHP_IDX_CMD2:   ctrl_rd = cmd2_ff;
      `PDHP_IDX_CMD3:   ctrl_rd = cmd3_ff;
      `PDHP_IDX_REV:    ctrl_rd = REV_CODE;
      default:          ctrl_rd = 8'h00;
    endcase
  end

  // Latch read data on the strobe; hold it for the host
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_ff <= 10'h000;
    end else if (rd) begin
      case (req_ff.sel)
        `PDHP_SEL_MODE: rdata_ff <= {2'h0, mode_ff};
        `PDHP_SEL_ADDR: rdata_ff <= {2'h0, addr_ff};
        `PDHP_SEL_CTRL: rdata_ff <= {2'h0, ctrl_rd};
        default: begin
          if (!eight_bit)    rdata_ff <= ram_val;
          else if (!half_ff) rdata_ff <= {2'h0, ram_val[9:2]};
          else               rdata_ff <= {8'h00, ram_val[1:0]};
        end
      endcase
    end
  end

  assign host_data_out = rdata_ff;
  // Drive while strobe active on a read; upper lines zero in 8-bit mode
  assign host_data_oe  = (sync2_ff && req_ff.rd && !por_active) ? 10'h3FF : 10'h000;

endmodule : pdhp_host_port
`default_nettype wire

/* pdhp_host_port_props.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module pdhp_host_port_chk
  import pdhp_pkg::*;
#(
  parameter int POR_CYCLES = 125  // Power-on reset length in cycles
) (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        read_not_write,
  input wire logic        chip_enable_n,
  input wire logic [9:0]  host_data_oe,
  input wire logic        por_active,
  input wire logic        device_selected,
  input wire logic        dac_ten_bit,
  input wire logic [29:0] palette_rd_data,
  input wire logic        calibrate_start,
  input wire logic        programmable_clock_out,
  input wire logic        load_clock_out,
  input wire logic [7:0]  command_one,
  input wire logic [7:0]  command_two,
  input wire logic [7:0]  command_three
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // Length of the current power-on hold; a wide counter so it cannot wrap
  logic [15:0] por_cnt_ff;
  always_ff @(posedge clk_sys) begin
    if (reset || !por_active) begin
      por_cnt_ff <= 16'h0000;
    end else begin
      por_cnt_ff <= por_cnt_ff + 16'h0001;
    end
  end
  a_reset_cmd_vals: assert property ($fell(reset) |->
    command_one == 8'h00 && command_two == 8'hFF && command_three == 8'hFF)
    else $error("command registers wrong after reset");
  a_por_hold_len: assert property ($fell(por_active) |->
    por_cnt_ff >= POR_CYCLES - 1 && por_cnt_ff <= POR_CYCLES + 1)
    else $error("power-on hold has wrong length");
  a_por_starts: assert property ($fell(reset) |-> ##1 por_active [*2])
    else $error("power-on hold missing after reset");
  // The read flag reaches the port logic two stages after the pin
  a_drive_on_read: assert property (|host_data_oe |-> $past(read_not_write, 2))
    else $error("bus driven on a write");
  a_idle_no_drive: assert property (chip_enable_n [*3] |-> host_data_oe == 10'h000)
    else $error("bus driven with strobe idle");
  a_desel_zero: assert property (!device_selected [*2] |-> palette_rd_data == 30'h0)
    else $error("lookup data not zero while deselected");
  a_low_res_lsb: assert property (!dac_ten_bit [*2] |->
    (palette_rd_data & 30'h00300C03) == 30'h0)
    else $error("low bits not forced in 8-bit resolution");
  a_cal_one_pulse: assert property (calibrate_start |=> !calibrate_start)
    else $error("calibrate pulse longer than one cycle");
  a_prg_div_32: assert property ($changed(programmable_clock_out) |->
    ##16 $changed(programmable_clock_out))
    else $error("programmable clock not divided by 32");
  a_load_div_4: assert property ($changed(load_clock_out) |->
    ##1 $stable(load_clock_out) ##1 $changed(load_clock_out))
    else $error("load clock not divided by 4");
endmodule : pdhp_host_port_chk
////////////////////////////////////////////////////////////////////////////////
bind pdhp_host_port pdhp_host_port_chk #(.POR_CYCLES(POR_CYCLES)) i_chk (
  .clk_sys, .reset, .read_not_write, .chip_enable_n, .host_data_oe, .por_active,
  .device_selected, .dac_ten_bit, .palette_rd_data, .calibrate_start,
  .programmable_clock_out, .load_clock_out, .command_one, .command_two, .command_three);
`default_nettype wire

/* pdhp_host_model.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module pdhp_host_model (
  input  wire logic       clk_sys,
  input  wire logic [9:0] host_data_out,
  output var  logic       chip_enable_n,
  output var  logic       read_not_write,
  output var  logic [1:0] target_sel,
  output var  logic [9:0] host_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    chip_enable_n = 1'b1;
    read_not_write = 1'b1;
    target_sel = 2'h0;
    host_drive = 10'h155;
  end
  // One bus cycle: controls settle 3 clk ahead of the strobe, strobe low 5 clk
  // Caller waits out the power-on hold first
  task automatic access(input logic rd, input logic [1:0] sel, input logic [9:0] wd,
                        output logic [9:0] rdat);
    @(posedge clk_sys);
    read_not_write <= rd;
    target_sel <= sel;
    host_drive <= rd ? ~host_drive : wd;
    repeat (3) @(posedge clk_sys);
    chip_enable_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rdat = host_data_out;
    chip_enable_n <= 1'b1;
    // Released lines must not keep the last value
    host_drive <= ~host_drive;
  endtask : access
  // Palette value over the byte bus: high eight bits, then low two
  task automatic pal_wr(input logic [9:0] v);
    logic [9:0] d;
    access(1'b0, 2'h1, {2'b00, v[9:2]}, d);
    access(1'b0, 2'h1, {8'h00, v[1:0]}, d);
  endtask : pal_wr
  // Read back in the same split; up collects lines 9..8
  task automatic pal_rd(output logic [9:0] v, output logic [1:0] up);
    logic [9:0] a;
    logic [9:0] b;
    access(1'b1, 2'h1, 10'h000, a);
    access(1'b1, 2'h1, 10'h000, b);
    v = {a[7:0], b[1:0]};
    up = a[9:8] | b[9:8];
  endtask : pal_rd
endmodule : pdhp_host_model
`default_nettype wire

/* tb_top.sv */
`include "pdhp_cfg.svh"
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pdhp_pkg::*;
  localparam int POR = 4;  // Shortened power-on hold
  logic        clk_sys, reset, ce_n, rnw, ps_hi, ps_lo, pix_stb;
  logic        sel_o, norm, ten, restart, cal;
  logic [1:0]  sel, up;
  logic [9:0]  drv, bus_in, dout, doe, d;
  logic [23:0] pix;
  logic [7:0]  rd_idx, c1, c2, c3, mask;
  logic [29:0] rd_data;
  logic        por;
  int          bad_count, compares, n_restart, n_cal;
  localparam logic [9:0] R = 10'h2A7, G = 10'h15B, B = 10'h3FD;
  // Bus wire: design drives where enabled, host elsewhere
  assign bus_in = (doe & dout) | (~doe & drv);
  pdhp_host_port #(.POR_CYCLES(POR)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .chip_enable_n(ce_n), .read_not_write(rnw),
    .target_select_hi(sel[1]), .target_select_lo(sel[0]), .host_data_in(bus_in),
    .host_data_out(dout), .host_data_oe(doe), .palette_select_in_hi(ps_hi),
    .palette_select_in_lo(ps_lo), .pixel_port_in(pix), .pixel_capture_strobe(pix_stb),
    .palette_rd_index(rd_idx), .palette_rd_data(rd_data), .device_selected(sel_o),
    .normal_mode(norm), .dac_ten_bit(ten), .sequence_restart(restart),
    .calibrate_start(cal), .programmable_clock_out(), .load_clock_out(),
    .por_active(por), .command_one(c1), .command_two(c2), .command_three(c3),
    .pixel_mask(mask));
  pdhp_host_model i_host (.clk_sys(clk_sys), .host_data_out(dout), .chip_enable_n(ce_n),
    .read_not_write(rnw), .target_sel(sel), .host_drive(drv));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Pulse counters, kept outside reset
  always @(posedge clk_sys) begin
    if (!reset && restart) n_restart++;
    if (!reset && cal) n_cal++;
  end
  task automatic chk(input string nm, input logic [29:0] exp, input logic [29:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic t_reset_state();
    for (int i = 0; i < 40 && por !== 1'b0; i++) @(posedge clk_sys);
    chk("por_active", 0, por);
    chk("cmd_regs", 24'h00FFFF, {c1, c2, c3});
    i_host.access(1'b1, `PDHP_SEL_MODE, 10'h000, d);
    chk("mode_reset", 10'h0FF, d);
  endtask : t_reset_state
  task automatic t_addr_ctrl();
    i_host.access(1'b0, `PDHP_SEL_ADDR, 10'h0C3, d);
    i_host.access(1'b1, `PDHP_SEL_ADDR, 10'h000, d);
    chk("addr", 8'hC3, d[7:0]);
    for (int i = 0; i < 4; i++) begin
      i_host.access(1'b0, `PDHP_SEL_ADDR, 10'h004 + 10'(i), d);
      i_host.access(1'b0, `PDHP_SEL_CTRL, 10'h03C + 10'(i), d);
      i_host.access(1'b1, `PDHP_SEL_CTRL, 10'h000, d);
      chk("ctrl_read", 8'h3C + 8'(i), d[7:0]);
    end
    chk("cmd_outs", 24'h3D3E3F, {c1, c2, c3});
    chk("mask_out", 8'h3C, mask);
  endtask : t_addr_ctrl
  task automatic t_mode();
    int n0;
    n0 = n_restart;
    i_host.access(1'b0, `PDHP_SEL_MODE, 10'h00B, d);
    i_host.access(1'b0, `PDHP_SEL_MODE, 10'h00A, d);
    i_host.access(1'b0, `PDHP_SEL_MODE, 10'h00B, d);
    chk("restart_pulses", 1, n_restart - n0);
    chk("normal_ten", 2'b11, {norm, ten});
    i_host.access(1'b1, `PDHP_SEL_MODE, 10'h000, d);
    chk("mode_read", 10'h00B, d);
    n0 = n_cal;
    i_host.access(1'b0, `PDHP_SEL_MODE, 10'h02B, d);
    i_host.access(1'b0, `PDHP_SEL_MODE, 10'h00B, d);
    chk("cal_pulses", 1, n_cal - n0);
    chk("selected", 1, sel_o);
  endtask : t_mode
  task automatic t_palette();
    logic [9:0] v;
    i_host.access(1'b0, `PDHP_SEL_ADDR, 10'h0FF, d);
    i_host.pal_wr(R);
    i_host.pal_wr(G);
    i_host.pal_wr(B);
    i_host.access(1'b1, `PDHP_SEL_ADDR, 10'h000, d);
    chk("addr_wrap_wr", 8'h00, d[7:0]);
    rd_idx <= 8'hFF;
    repeat (3) @(posedge clk_sys);
    chk("ram_entry", {R, G, B}, rd_data);
    i_host.access(1'b0, `PDHP_SEL_ADDR, 10'h0FF, d);
    i_host.pal_wr(10'h111);
    i_host.access(1'b0, `PDHP_SEL_ADDR, 10'h0FF, d);
    i_host.pal_rd(v, up);
    chk("rd_red", {R, 2'b00}, {v, up});
    i_host.pal_rd(v, up);
    chk("rd_green", {G, 2'b00}, {v, up});
    i_host.pal_rd(v, up);
    chk("rd_blue", {B, 2'b00}, {v, up});
    i_host.access(1'b1, `PDHP_SEL_ADDR, 10'h000, d);
    chk("addr_wrap_rd", 8'h00, d[7:0]);
  endtask : t_palette
  task automatic t_desel_capture();
    ps_hi <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("desel", 1'b0, sel_o);
    chk("desel_data", 30'h0, rd_data);
    ps_hi <= 1'b0;
    pix <= 24'hA5C33C;
    pix_stb <= 1'b1;
    repeat (4) @(posedge clk_sys);
    pix_stb <= 1'b0;
    chk("reselect", 1, sel_o);
    i_host.access(1'b0, `PDHP_SEL_ADDR, 10'h000, d);
    i_host.access(1'b0, `PDHP_SEL_CTRL, 10'h077, d);
    i_host.access(1'b1, `PDHP_SEL_CTRL, 10'h000, d);
    chk("capture", 8'h3C, d[7:0]);
  endtask : t_desel_capture
  task automatic t_low_res();
    i_host.access(1'b0, `PDHP_SEL_MODE, 10'h009, d);
    repeat (3) @(posedge clk_sys);
    chk("ten_bit", 0, ten);
    chk("lsb_forced", 30'h0, rd_data & 30'h00300C03);
  endtask : t_low_res
  initial begin
    reset = 1'b1;
    ps_hi = 1'b0;
    ps_lo = 1'b0;
    pix = 24'h000000;
    pix_stb = 1'b0;
    rd_idx = 8'h00;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset_state();
    t_addr_ctrl();
    t_mode();
    t_palette();
    t_desel_capture();
    t_low_res();
    report_and_stop();
  end
  // Watchdog: the full run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
